// *** core/sats_sched.v ***
// command staging and tag scheduler of the scsi adapter
`timescale 1ns/10ps
`default_nettype none
`include "sats_consts.vh"
module sats_sched #(
  parameter [7:0] FW_VERSION = 8'h01,  // arbitrary firmware version
  parameter [7:0] FW_LEVEL   = 8'h00,  // level within version, from zero
  parameter RST_CYCLES = (`SATS_RST_PULSE_NS * `SATS_CLK_MHZ + 999) / 1000
) (
  input  wire        clk,           // adapter clock, 250 mhz
  input  wire        nrst,          // hardware reset, active low
  input  wire [11:0] addr,          // register byte address
  input  wire [15:0] wdata,         // register write data
  input  wire        wr,            // write strobe
  input  wire        rd,            // read strobe
  output reg  [15:0] rdata,         // read data, cycle after rd
  input  wire        bus_free,      // arbitration won this cycle
  input  wire        connected,     // adapter connected to a lun
  input  wire [3:0]  conn_tag,      // tag of the connected command
  input  wire        scsi_done,     // scsi command complete pulse
  input  wire [3:0]  scsi_done_tag, // tag of completed scsi command
  input  wire        buf_done,      // executing buffer command done
  output reg         scsi_send,     // command sent on the bus pulse
  output reg  [3:0]  scsi_send_tag, // tag of the sent command
  output reg         buf_start,     // buffer command start pulse
  output reg  [3:0]  buf_start_tag, // tag of started buffer command
  output reg         resume,        // continue data transfer pulse
  output reg  [3:0]  resume_tag,    // tag to resume
  output wire        scsi_rst       // scsi bus reset line, high active
);
  localparam N = `SATS_NUM_TAGS;

  // reset release through two flops
  reg rs1_ff;
  reg rs2_ff;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  wire rst_n = rs2_ff;

  // tag array and host registers
  reg [1:0]  st_ff [0:N-1];
  reg        ty_ff [0:N-1];
  reg [15:0] unsent_ff;
  reg [15:0] stat_ff;
  reg [15:0] sext_ff;
  reg [7:0]  stack0_ff;
  reg [15:0] cmd_ff;
  reg        pend_ff;
  reg        busy_ff;
  reg        rst_trig_ff;
  reg [1:0]  nxt_st [0:N-1];
  reg        nxt_ty [0:N-1];
  reg [15:0] nxt_unsent;
  reg        nxt_bstart;
  reg [3:0]  nxt_btag;
  integer    i, j, k, m;  // one loop index per process, none shared

  wire [3:0] op      = cmd_ff[`SATS_CMD_OP_HI:`SATS_CMD_OP_LO];
  wire [4:0] tag5    = cmd_ff[`SATS_CMD_TAG_HI:`SATS_CMD_TAG_LO];
  wire [3:0] tag     = tag5[3:0];
  wire [4:0] clr5    = stack0_ff[`SATS_STK_TAG_HI:`SATS_STK_TAG_LO];
  wire [3:0] clr_tag = clr5[3:0];

  // per-type masks of the array
  reg [15:0] use_m [0:1];
  reg [15:0] nxt_m [0:1];
  reg [15:0] rdy_m [0:1];
  always @* begin
    use_m[0] = 16'h0000;
    use_m[1] = 16'h0000;
    nxt_m[0] = 16'h0000;
    nxt_m[1] = 16'h0000;
    rdy_m[0] = 16'h0000;
    rdy_m[1] = 16'h0000;
    for (j = 0; j < N; j = j + 1) begin
      use_m[ty_ff[j]][j] = (st_ff[j] != `SATS_ST_FREE);
      nxt_m[ty_ff[j]][j] = (st_ff[j] == `SATS_ST_NEXT);
      rdy_m[ty_ff[j]][j] = (st_ff[j] == `SATS_ST_READY);
    end
  end

  // scans for next and lowest ready entry of each type
  wire [1:0] nfound;
  wire [1:0] rfound;
  wire [3:0] nidx [0:1];
  wire [3:0] ridx [0:1];
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_scan
      sats_lowbit #(.N(N), .W(4)) u_next (
        .vec   (nxt_m[t]),
        .found (nfound[t]),
        .idx   (nidx[t])
      );
      // lowest ready tag wins the scan
      sats_lowbit #(.N(N), .W(4)) u_ready (
        .vec   (rdy_m[t]),
        .found (rfound[t]),
        .idx   (ridx[t])
      );
    end
  endgenerate

  // lowest unsent tag goes out first
  wire       us_found;
  wire [3:0] us_idx;
  sats_lowbit #(.N(N), .W(4)) u_unsent (
    .vec   (unsent_ff),
    .found (us_found),
    .idx   (us_idx)
  );

  // count of stored unsent scsi commands
  reg [4:0] us_cnt;
  always @* begin
    us_cnt = 5'h00;
    for (k = 0; k < N; k = k + 1) begin
      us_cnt = us_cnt + {4'h0, unsent_ff[k]};
    end
  end

  // decode of the staged command; done inputs defer it one cycle
  wire defer    = scsi_done | buf_done;
  wire go       = pend_ff & ~defer;
  wire sched_op = (op == `SATS_OP_SCSI) | (op == `SATS_OP_BUF);
  wire ty_new   = (op == `SATS_OP_BUF);
  // only tags 0 to F are accepted for scsi and buffer commands
  wire bad_tag  = sched_op & tag5[4];
  // sixteen stored unsent commands hold a scsi command back
  wire us_full  = (us_cnt == 5'h10);
  wire stall    = (op == `SATS_OP_SCSI) & us_full;
  wire arrive   = go & sched_op & ~bad_tag & ~stall;
  wire do_clr   = go & (op == `SATS_OP_CLEAR) & ~clr5[4];
  wire do_cont  = go & (op == `SATS_OP_CONT);
  wire do_info  = go & (op == `SATS_OP_INFO);
  wire do_brst  = go & (op == `SATS_OP_BUSRST);
  wire do_send  = bus_free & us_found;

  // completion of the executing entry per type
  wire clr_exec = do_clr & (st_ff[clr_tag] == `SATS_ST_EXEC);
  wire s_done   = scsi_done & (st_ff[scsi_done_tag] == `SATS_ST_EXEC) &
                  (ty_ff[scsi_done_tag] == `SATS_TY_SCSI);
  reg        buf_exec_vld_ff;
  reg [3:0]  buf_exec_tag_ff;
  wire [1:0] fin;
  wire [3:0] fin_tag [0:1];
  assign fin[0]     = s_done | (clr_exec & (ty_ff[clr_tag] == 1'b0));
  assign fin[1]     = (buf_done & buf_exec_vld_ff) |
                      (clr_exec & (ty_ff[clr_tag] == 1'b1));
  assign fin_tag[0] = s_done ? scsi_done_tag : clr_tag;
  assign fin_tag[1] = (buf_done & buf_exec_vld_ff) ? buf_exec_tag_ff
                                                    : clr_tag;

  // next state of the array
  always @* begin
    for (i = 0; i < N; i = i + 1) begin
      nxt_st[i] = st_ff[i];
      nxt_ty[i] = ty_ff[i];
    end
    nxt_unsent = unsent_ff;
    nxt_bstart = 1'b0;
    nxt_btag   = 4'h0;
    // each type runs the same steps on its own masks
    for (i = 0; i < 2; i = i + 1) begin
      if (fin[i]) begin
        // finished tag becomes free for reuse
        nxt_st[fin_tag[i]] = `SATS_ST_FREE;
        if (nfound[i]) begin
          nxt_st[nidx[i]] = `SATS_ST_EXEC;
          if (i == 1) begin
            nxt_bstart = 1'b1;
            nxt_btag   = nidx[i];
          end
        end
        // no ready entry leaves the type without next
        if (rfound[i]) begin
          nxt_st[ridx[i]] = `SATS_ST_NEXT;
        end
      end
    end
    // arrival slot depends on what the type holds
    if (arrive) begin
      nxt_ty[tag] = ty_new;
      if (use_m[ty_new] == 16'h0000) begin
        nxt_st[tag] = `SATS_ST_EXEC;
        nxt_bstart  = ty_new;
        nxt_btag    = tag;
      end else if (nxt_m[ty_new] == 16'h0000) begin
        nxt_st[tag] = `SATS_ST_NEXT;
      end else begin
        nxt_st[tag] = `SATS_ST_READY;
      end
      // every scsi command is stored until sent
      if (!ty_new) begin
        nxt_unsent[tag] = 1'b1;
      end
    end
    // retry the bus each cycle, send one when free
    if (do_send) begin
      nxt_unsent[us_idx] = 1'b0;
    end
    // clear tag frees entry and drops unsent copy
    if (do_clr) begin
      nxt_st[clr_tag]     = `SATS_ST_FREE;
      nxt_unsent[clr_tag] = 1'b0;
    end
    // bus reset drops every outstanding command
    if (do_brst) begin
      for (i = 0; i < N; i = i + 1) begin
        nxt_st[i] = `SATS_ST_FREE;
      end
      nxt_unsent = 16'h0000;
      nxt_bstart = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (m = 0; m < N; m = m + 1) begin
        st_ff[m] <= `SATS_ST_FREE;
        ty_ff[m] <= `SATS_TY_SCSI;
      end
      unsent_ff <= 16'h0000;
    end else begin
      for (m = 0; m < N; m = m + 1) begin
        st_ff[m] <= nxt_st[m];
        ty_ff[m] <= nxt_ty[m];
      end
      unsent_ff <= nxt_unsent;
    end
  end

  // tracks which buffer tag is executing for buf_done
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_exec_vld_ff <= 1'b0;
      buf_exec_tag_ff <= 4'h0;
      buf_start       <= 1'b0;
      buf_start_tag   <= 4'h0;
      scsi_send       <= 1'b0;
      scsi_send_tag   <= 4'h0;
    end else begin
      buf_start     <= nxt_bstart;
      buf_start_tag <= nxt_btag;
      scsi_send     <= do_send & ~do_brst;
      scsi_send_tag <= us_idx;
      if (nxt_bstart) begin
        buf_exec_vld_ff <= 1'b1;
        buf_exec_tag_ff <= nxt_btag;
      end else if (fin[1] | do_brst) begin
        buf_exec_vld_ff <= 1'b0;
      end
    end
  end

  // command staging, busy bit, status and extension registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff      <= `SATS_RST_VAL16;
      stack0_ff   <= 8'h00;
      pend_ff     <= 1'b0;
      busy_ff     <= 1'b0;
      stat_ff     <= `SATS_RST_VAL16;
      sext_ff     <= `SATS_RST_VAL16;
      rst_trig_ff <= 1'b0;
      resume      <= 1'b0;
      resume_tag  <= 4'h0;
    end else begin
      rst_trig_ff <= 1'b0;
      resume      <= 1'b0;
      if (wr && addr == `SATS_OFS_STACK0) begin
        stack0_ff <= wdata[7:0];
      end
      // command register writes are taken only while not busy
      if (wr && addr == `SATS_OFS_CMD && !busy_ff) begin
        cmd_ff  <= wdata;
        pend_ff <= 1'b1;
        busy_ff <= 1'b1;
      // busy stays for a scsi command while sixteen are unsent
      end else if (go && !(sched_op && !bad_tag && stall)) begin
        pend_ff <= 1'b0;
        busy_ff <= 1'b0;
      end
      // completion writes status with its tag
      if (fin[0] & ~do_clr) begin
        stat_ff <= {`SATS_CC_OK, 4'h0, fin_tag[0]};
      end else if (fin[1] & ~do_clr) begin
        stat_ff <= {`SATS_CC_OK, 4'h0, fin_tag[1]};
      end
      if (go) begin
        if (bad_tag) begin
          stat_ff <= {`SATS_CC_REJECT, 3'h0, tag5};
        end else if (do_clr) begin
          // reset the bus only if the tag is on the bus
          rst_trig_ff <= (ty_ff[clr_tag] == `SATS_TY_SCSI) &
                         (st_ff[clr_tag] != `SATS_ST_FREE) &
                         connected & (conn_tag == clr_tag);
          stat_ff     <= {`SATS_CC_OK, 3'h0, tag5};
        end else if (do_cont) begin
          resume     <= 1'b1;
          resume_tag <= tag;
        end else if (do_info) begin
          // version high byte, level low byte
          // level counts from zero within a version
          sext_ff <= {FW_VERSION, FW_LEVEL};
          stat_ff <= {`SATS_CC_OK, 3'h0, tag5};
        end else if (do_brst) begin
          // fixed bus reset status, tag ignored
          rst_trig_ff <= 1'b1;
          stat_ff     <= {`SATS_CC_BUSRST, `SATS_LOW_BUSRST};
        end else if (!sched_op) begin
          stat_ff <= {`SATS_CC_REJECT, 3'h0, tag5};
        end
      end
    end
  end

  // reset line pulse, at least the minimum reset time
  sats_pulse #(.LEN(RST_CYCLES), .CW(16)) u_rst (
    .clk   (clk),
    .rst_n (rst_n),
    .trig  (rst_trig_ff),
    .pulse (scsi_rst)
  );

  // read mux; busy is live in the status word
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `SATS_RST_VAL16;
    end else if (rd) begin
      case (addr)
        `SATS_OFS_STAT: begin
          rdata <= stat_ff | ({15'h0000, busy_ff} << `SATS_STAT_BUSY);
        end
        `SATS_OFS_SEXT:    rdata <= sext_ff;
        `SATS_OFS_STACK0:  rdata <= {8'h00, stack0_ff};
        `SATS_OFS_CMD:     rdata <= cmd_ff;
        `SATS_OFS_SUMMARY: rdata <= {3'h0, us_cnt, 6'h00,
                                     buf_exec_vld_ff, busy_ff};
        default:           rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// *** core/sats_consts.vh ***
// constants for the tag scheduler: offsets, fields, codes and timing
`ifndef SATS_CONSTS_VH
`define SATS_CONSTS_VH

// register byte offsets on the plain register port
`define SATS_OFS_SEXT      12'hD58
`define SATS_OFS_STACK0    12'hD50
`define SATS_OFS_SUMMARY   12'hD54
`define SATS_OFS_CMD       12'hD5C
`define SATS_OFS_STAT      12'hD5E

// command register fields
`define SATS_CMD_OP_HI     11
`define SATS_CMD_OP_LO     8
`define SATS_CMD_TAG_HI    4
`define SATS_CMD_TAG_LO    0

// stack byte 0 tag field of the clear-tag command
`define SATS_STK_TAG_HI    4
`define SATS_STK_TAG_LO    0

// operation codes
`define SATS_OP_SCSI       4'h0
`define SATS_OP_BUF        4'h1
`define SATS_OP_CLEAR      4'h6
`define SATS_OP_CONT       4'h7
`define SATS_OP_INFO       4'h8
`define SATS_OP_BUSRST     4'h9

// tag entry states
`define SATS_ST_FREE       2'h0
`define SATS_ST_EXEC       2'h1
`define SATS_ST_NEXT       2'h2
`define SATS_ST_READY      2'h3

// entry types
`define SATS_TY_SCSI       1'h0
`define SATS_TY_BUF        1'h1

// completion codes and status fields
`define SATS_CC_OK         8'h00
`define SATS_CC_BUSRST     8'h83
`define SATS_CC_REJECT     8'hC0
`define SATS_LOW_BUSRST    8'h1F
`define SATS_STAT_BUSY     7
`define SATS_NUM_TAGS      16
`define SATS_RST_VAL16     16'h0000

// scsi reset pulse length, least time
`define SATS_RST_PULSE_NS  25000
`define SATS_CLK_MHZ       250

`endif

// *** core/sats_lowbit.v ***
// lowest-index set bit finder used for tag scans
`timescale 1ns/10ps
`default_nettype none
module sats_lowbit #(
  parameter N = 16,
  parameter W = 4
) (
  input  wire [N-1:0] vec,    // candidate bits
  output reg          found,  // any bit set
  output reg  [W-1:0] idx     // index of lowest set bit
);
  integer i;

  // scan from the top so the lowest index wins
  always @* begin
    found = 1'b0;
    idx   = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (vec[i]) begin
        found = 1'b1;
        idx   = i[W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// *** core/sats_pulse.v ***
// fixed-length pulse generator for the scsi reset line
`timescale 1ns/10ps
`default_nettype none
module sats_pulse #(
  parameter LEN = 6250,
  parameter CW  = 13
) (
  input  wire clk,     // adapter clock
  input  wire rst_n,   // synchronised reset, active low
  input  wire trig,    // one-cycle start request
  output wire pulse    // level high for len cycles
);
  reg [CW-1:0] cnt_ff;

  // a new trigger restarts the full length
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= {CW{1'b0}};
    end else if (trig) begin
      cnt_ff <= LEN[CW-1:0];
    end else if (cnt_ff != {CW{1'b0}}) begin
      cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign pulse = (cnt_ff != {CW{1'b0}});
endmodule
`default_nettype wire

// *** sim/sats_sched_checker.sv ***
// port checker for the tag scheduler
`timescale 1ns/10ps
`default_nettype none
`include "sats_consts.vh"
module sats_sched_checker #(
  parameter [7:0] FW_VERSION = 8'h01,
  parameter [7:0] FW_LEVEL   = 8'h00,
  parameter       RST_CYCLES = 8
) (
  input wire logic        clk,           // clock
  input wire logic        nrst,          // reset
  input wire logic [11:0] addr,          // address
  input wire logic [15:0] wdata,         // write data
  input wire logic        wr,            // write
  input wire logic        rd,            // read
  input wire logic [15:0] rdata,         // read data
  input wire logic        bus_free,      // bus won
  input wire logic        connected,     // lun linked
  input wire logic [3:0]  conn_tag,      // linked tag
  input wire logic        scsi_done,     // scsi done
  input wire logic [3:0]  scsi_done_tag, // done tag
  input wire logic        buf_done,      // buffer done
  input wire logic        scsi_send,     // sent
  input wire logic [3:0]  scsi_send_tag, // sent tag
  input wire logic        buf_start,     // buffer start
  input wire logic [3:0]  buf_start_tag, // start tag
  input wire logic        resume,        // resume
  input wire logic [3:0]  resume_tag,    // resume tag
  input wire logic        scsi_rst       // bus reset line
);
  // decoded command writes; a done in the execute cycle delays it
  wire cmd_wr  = wr && addr == `SATS_OFS_CMD;
  wire cont_wr = cmd_wr && wdata[11:8] == `SATS_OP_CONT;
  wire buf_wr  = cmd_wr && wdata[11:8] == `SATS_OP_BUF;
  wire clr_wr  = cmd_wr && wdata[11:8] == `SATS_OP_CLEAR;
  wire brst_wr = cmd_wr && wdata[11:8] == `SATS_OP_BUSRST;
  wire info_wr = cmd_wr && wdata[11:8] == `SATS_OP_INFO;
  wire quiet   = !(scsi_done || buf_done);
  wire rcause  = clr_wr || brst_wr;
  logic [15:0] run_ff;

  // width of the running reset pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      run_ff <= 16'h0000;
    else if (scsi_rst)
      run_ff <= run_ff + 16'h0001;
    else
      run_ff <= 16'h0000;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // command taken, then executed undelayed
  sequence s_run(op);
    op ##1 quiet;
  endsequence

  AST_RESUME_AT: assert property (
    s_run(cont_wr) |=> resume && resume_tag == $past(wdata[3:0], 2))
    else $error("resume pulse missing after continue");
  AST_RESUME_SRC: assert property (
    resume |-> $past(cont_wr, 2) || $past(cont_wr, 3))
    else $error("resume without continue command");
  AST_RST_START: assert property (
    s_run(brst_wr) |-> ##[1:4] scsi_rst)
    else $error("bus reset line not raised");
  AST_RST_LEN: assert property (
    $fell(scsi_rst) |-> run_ff == RST_CYCLES)
    else $error("bus reset pulse has wrong length");
  AST_RST_SRC: assert property (
    $rose(scsi_rst) |-> $past(rcause, 2) || $past(rcause, 3) ||
      $past(rcause, 4) || $past(rcause, 5))
    else $error("bus reset line raised without cause");
  AST_BUSRST_STAT: assert property (
    s_run(brst_wr) ##[2:4] (rd && addr == `SATS_OFS_STAT) |=>
      rdata == {`SATS_CC_BUSRST, `SATS_LOW_BUSRST})
    else $error("bus reset status wrong");
  AST_INFO_SEXT: assert property (
    s_run(info_wr) ##[2:4] (rd && addr == `SATS_OFS_SEXT) |=>
      rdata == {FW_VERSION, FW_LEVEL})
    else $error("information word wrong");
  AST_SEND_FREE: assert property (
    scsi_send |-> $past(bus_free))
    else $error("send without won arbitration");
  AST_BUF_SRC: assert property (
    buf_start |-> $past(buf_done) || $past(buf_done, 2) ||
      $past(buf_wr, 2) || $past(buf_wr, 3) ||
      $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("buffer start without cause");
endmodule

bind sats_sched sats_sched_checker #(
  .FW_VERSION(FW_VERSION), .FW_LEVEL(FW_LEVEL), .RST_CYCLES(RST_CYCLES)
) u_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .bus_free(bus_free), .connected(connected),
  .conn_tag(conn_tag), .scsi_done(scsi_done),
  .scsi_done_tag(scsi_done_tag), .buf_done(buf_done),
  .scsi_send(scsi_send), .scsi_send_tag(scsi_send_tag),
  .buf_start(buf_start), .buf_start_tag(buf_start_tag),
  .resume(resume), .resume_tag(resume_tag), .scsi_rst(scsi_rst)
);
`default_nettype wire

// *** sim/sats_bus_model.sv ***
// far-side scsi bus model: arbitration, link and completions
`timescale 1ns/10ps
`default_nettype none
module sats_bus_model (
  input  wire logic       clk,           // clock
  input  wire logic       scsi_send,     // sent pulse
  input  wire logic [3:0] scsi_send_tag, // sent tag
  output logic            bus_free,      // bus won
  output logic            connected,     // lun linked
  output logic      [3:0] conn_tag,      // linked tag
  output logic            scsi_done,     // done pulse
  output logic      [3:0] scsi_done_tag, // done tag
  output logic            buf_done       // buffer done
);
  logic       free_en = 1'b0;
  logic       slow = 1'b0;
  logic [1:0] ph_ff = 2'h0;
  logic [3:0] ctag = 4'h0;
  logic [3:0] dtag = 4'h0;
  logic [3:0] sent[$];

  initial begin
    connected = 1'b0;
    scsi_done = 1'b0;
    buf_done = 1'b0;
  end
  // slow mode wins arbitration one cycle in four
  always @(posedge clk) begin
    ph_ff <= ph_ff + 2'h1;
    if (scsi_send)
      sent.push_back(scsi_send_tag);
  end
  assign bus_free = free_en && (!slow || ph_ff == 2'h0);
  // released lines drive the inverse of the held tag
  assign conn_tag = connected ? ctag : ~ctag;
  assign scsi_done_tag = scsi_done ? dtag : ~dtag;

  task automatic arb(input logic en, input logic sl);
    @(posedge clk);
    free_en <= en;
    slow <= sl;
  endtask
  task automatic link(input logic on, input logic [3:0] t);
    @(posedge clk);
    connected <= on;
    ctag <= t;
  endtask
  task automatic done_buf();
    @(posedge clk);
    buf_done <= 1'b1;
    @(posedge clk);
    buf_done <= 1'b0;
  endtask
  task automatic done_scsi(input logic [3:0] t);
    @(posedge clk);
    dtag <= t;
    scsi_done <= 1'b1;
    @(posedge clk);
    scsi_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/test_sats_sched.sv ***
// self-checking testbench of the tag scheduler
`timescale 1ns/10ps
`default_nettype none
`include "sats_consts.vh"
module test_sats_sched;
  localparam logic [7:0] VER = 8'h2A; // arbitrary version
  localparam logic [7:0] LVL = 8'h00; // first level of it
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        bus_free, connected, scsi_done, buf_done;
  logic        scsi_send, buf_start, resume, scsi_rst;
  logic [3:0]  conn_tag, scsi_done_tag, scsi_send_tag;
  logic [3:0]  buf_start_tag, resume_tag, last_bs, last_res;
  logic [15:0] n_bs = 16'h0000;
  logic [15:0] n_res = 16'h0000;
  logic [15:0] n_rst = 16'h0000;
  logic [15:0] rst_run = 16'h0000;
  logic [15:0] rst_len = 16'h0000;
  int          miscompares = 0;
  int          n_checks = 0;

  always #2 clk = ~clk;

  sats_sched #(.FW_VERSION(VER), .FW_LEVEL(LVL), .RST_CYCLES(8)) DUT (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .bus_free(bus_free), .connected(connected),
    .conn_tag(conn_tag), .scsi_done(scsi_done),
    .scsi_done_tag(scsi_done_tag), .buf_done(buf_done),
    .scsi_send(scsi_send), .scsi_send_tag(scsi_send_tag),
    .buf_start(buf_start), .buf_start_tag(buf_start_tag),
    .resume(resume), .resume_tag(resume_tag), .scsi_rst(scsi_rst));
  sats_bus_model mdl (
    .clk(clk), .scsi_send(scsi_send), .scsi_send_tag(scsi_send_tag),
    .bus_free(bus_free), .connected(connected), .conn_tag(conn_tag),
    .scsi_done(scsi_done), .scsi_done_tag(scsi_done_tag),
    .buf_done(buf_done));

  // record pulses and reset widths seen on the outputs
  always @(posedge clk) begin
    if (buf_start) begin
      n_bs <= n_bs + 16'h0001;
      last_bs <= buf_start_tag;
    end
    if (resume) begin
      n_res <= n_res + 16'h0001;
      last_res <= resume_tag;
    end
    if (scsi_rst)
      rst_run <= rst_run + 16'h0001;
    else if (rst_run != 16'h0000) begin
      rst_len <= rst_run;
      n_rst <= n_rst + 16'h0001;
      rst_run <= 16'h0000;
    end
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic expect_reg(input string what, input logic [11:0] a,
                            input logic [15:0] exp);
    logic [15:0] got;
    rd_reg(a, got);
    check(what, exp, got);
  endtask
  // three idle cycles keep commands clear of busy
  task automatic cmd(input logic [3:0] op, input logic [4:0] tag);
    wr_reg(`SATS_OFS_CMD, {4'h0, op, 3'h0, tag});
    repeat (3) @(posedge clk);
  endtask

  task automatic t_regs();
    expect_reg("sext reset", `SATS_OFS_SEXT, 16'h0000);
    expect_reg("status reset", `SATS_OFS_STAT, 16'h0000);
    expect_reg("unmapped", 12'h000, 16'h0000);
    wr_reg(`SATS_OFS_SEXT, 16'hFFFF);
    expect_reg("sext read only", `SATS_OFS_SEXT, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_immediate();
    logic [15:0] n0;
    cmd(`SATS_OP_INFO, 5'h03);
    expect_reg("info word", `SATS_OFS_SEXT, {VER, LVL});
    expect_reg("info status", `SATS_OFS_STAT, 16'h0003);
    cmd(`SATS_OP_SCSI, 5'h10);
    expect_reg("tag range", `SATS_OFS_STAT, 16'hC010);
    n0 = n_res;
    cmd(`SATS_OP_CONT, 5'h02);
    check("resume count", n0 + 16'h0001, n_res);
    check("resume tag", 16'h0002, {12'h000, last_res});
    expect_reg("continue status", `SATS_OFS_STAT, 16'hC010);
    $display("test immediate done");
  endtask
  task automatic t_buf();
    logic [3:0]  order[7] = '{4'h4, 4'h5, 4'h1, 4'h6, 4'h9, 4'h2, 4'h0};
    logic [15:0] n0;
    n0 = n_bs;
    for (int t = 3; t < 7; t++)
      cmd(`SATS_OP_BUF, 5'(t));
    check("first start", 16'h0003, {12'h000, last_bs});
    expect_reg("buffer busy", `SATS_OFS_SUMMARY, 16'h0002);
    for (int i = 0; i < 7; i++) begin
      if (i == 1) begin
        cmd(`SATS_OP_BUF, 5'h01);
        cmd(`SATS_OP_BUF, 5'h09);
      end
      // three buffers outstanding at most here
      if (i == 5) begin
        cmd(`SATS_OP_BUF, 5'h02);
        cmd(`SATS_OP_BUF, 5'h00);
      end
      mdl.done_buf();
      repeat (3) @(posedge clk);
      check("buf order", {12'h000, order[i]}, {12'h000, last_bs});
      if (i == 0)
        expect_reg("done status", `SATS_OFS_STAT, 16'h0003);
    end
    mdl.done_buf();
    repeat (3) @(posedge clk);
    check("start count", n0 + 16'h0008, n_bs);
    $display("test buf done");
  endtask
  task automatic t_scsi();
    logic [15:0] v;
    logic [15:0] n0;
    for (int t = 15; t >= 0; t--) begin
      cmd(`SATS_OP_SCSI, 5'(t));
      rd_reg(`SATS_OFS_STAT, v);
      check("busy after stage", 16'h0000, {15'h0000, v[7]});
    end
    expect_reg("unsent count", `SATS_OFS_SUMMARY, 16'h1000);
    mdl.arb(1'b1, 1'b1);
    repeat (100) @(posedge clk);
    check("sent count", 16'h0010, 16'(mdl.sent.size()));
    for (int i = 0; i < 16; i++)
      check("send order", 16'(i), {12'h000, mdl.sent[i]});
    mdl.link(1'b1, 4'hF);
    n0 = n_rst;
    wr_reg(`SATS_OFS_STACK0, 16'h00EE);
    cmd(`SATS_OP_CLEAR, 5'h00);
    repeat (12) @(posedge clk);
    check("no reset unlinked", n0, n_rst);
    wr_reg(`SATS_OFS_STACK0, 16'h00EF);
    cmd(`SATS_OP_CLEAR, 5'h00);
    repeat (12) @(posedge clk);
    check("reset linked", n0 + 16'h0001, n_rst);
    mdl.link(1'b0, 4'h0);
    $display("test scsi done");
  endtask
  task automatic t_busrst();
    logic [15:0] n0;
    mdl.arb(1'b0, 1'b0);
    // tag 14 was freed by the clear
    cmd(`SATS_OP_SCSI, 5'h0E);
    expect_reg("one unsent", `SATS_OFS_SUMMARY, 16'h0100);
    n0 = n_rst;
    cmd(`SATS_OP_BUSRST, 5'h1F);
    expect_reg("reset status", `SATS_OFS_STAT, 16'h831F);
    repeat (12) @(posedge clk);
    check("reset pulses", n0 + 16'h0001, n_rst);
    check("reset width", 16'h0008, rst_len);
    expect_reg("all dropped", `SATS_OFS_SUMMARY, 16'h0000);
    mdl.arb(1'b1, 1'b0);
    cmd(`SATS_OP_SCSI, 5'h03);
    // the model logs the send on this edge; look one later
    @(posedge clk);
    check("send after reset", 16'h0011, 16'(mdl.sent.size()));
    cmd(`SATS_OP_CONT, 5'h03);
    check("resume sent tag", 16'h0003, {12'h000, last_res});
    mdl.done_scsi(4'h3);
    repeat (3) @(posedge clk);
    expect_reg("scsi status", `SATS_OFS_STAT, 16'h0003);
    $display("test busrst done");
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_immediate();
    t_buf();
    t_scsi();
    t_busrst();
    complete_run();
  end
  // tests need a few hundred cycles; cut a hang short
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
